// >>> rtl/dsair_channel.sv
// module: one short-address dma channel, idle and repeat modes, apb slave
//
// Local design decisions: the APB register port and the register offsets.
`timescale 1ns/1ps
module dsair_channel (
  // clock and reset
  input  wire logic        CLK,
  input  wire logic        RSTN,
  // apb slave
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  // activation requests, one level per source
  input  wire logic [6:0]  REQ,
  // external request pin, from outside the clock domain
  input  wire logic        EXT_REQ_PIN,
  // system bus master
  output logic             BUS_REQ,
  output logic             BUS_WRITE,
  output logic             BUS_WORD,
  output logic      [23:0] BUS_ADDR,
  output logic      [15:0] BUS_WDATA,
  input  wire logic [15:0] BUS_RDATA,
  input  wire logic        BUS_ACK,
  // request acknowledge back to the source
  output logic      [6:0]  REQ_ACK,
  // interrupt
  output logic             IRQ
);
  import dsair_pkg::*;

  //============================================================================
  // registers
  logic [23:0]            mem_addr_q;
  logic [7:0]             io_addr_q;
  logic [15:0]            count_q;
  logic                   active_q;
  logic                   size_q;
  logic                   dir_q;
  dsair_mode_t            mode_q;
  dsair_src_t             src_q;
  logic [DSAIR_IRQ_W-1:0] irq_stat_q;
  logic [DSAIR_IRQ_W-1:0] irq_mask_q;
  dsair_state_t           state_q;
  logic [15:0]            data_q;
  logic [1:0]             ext_sync_q;
  logic                   done_ev;
  logic                   xfer_end;

  //============================================================================
  // external request synchroniser
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      ext_sync_q <= 2'h0;
    end else begin
      ext_sync_q <= {ext_sync_q[0], EXT_REQ_PIN};
    end
  end

  // source select; both modes share the same sources
  logic [6:0] req_all;
  logic       req_hit;
  assign req_all = {ext_sync_q[1] | REQ[6], REQ[5:0]};
  assign req_hit = (src_q != DSAIR_SRC_NONE) && req_all[src_q];
  logic rx_dir;
  assign rx_dir = (src_q == DSAIR_SRC_SER_RX);

  //============================================================================
  // apb decode; zero wait states
  logic wr_en;
  logic rd_en;
  logic unmapped;
  assign wr_en = PSEL && PENABLE && PWRITE;
  assign rd_en = PSEL && !PWRITE;
  assign PREADY = 1'b1;
  always_comb begin
    unique case (PADDR)
      DSAIR_OFF_MEM_ADDR, DSAIR_OFF_IO_ADDR, DSAIR_OFF_COUNT,
      DSAIR_OFF_CTRL, DSAIR_OFF_STATUS, DSAIR_OFF_IRQ_STAT,
      DSAIR_OFF_IRQ_MASK: unmapped = 1'b0;
      default:            unmapped = 1'b1;
    endcase
  end
  assign PSLVERR = PSEL && PENABLE && unmapped;

  // addresses, count and control fields other than active are only rewritten by software while the channel waits
  logic sw_wr;
  assign sw_wr = wr_en && (state_q == DSAIR_ST_WAIT);

  //============================================================================
  // transfer engine
  assign xfer_end = (state_q == DSAIR_ST_WRITE) && BUS_ACK;

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      state_q <= DSAIR_ST_WAIT;
    end else begin
      unique case (state_q)
        DSAIR_ST_WAIT: begin
          if (active_q && req_hit) begin
            state_q <= DSAIR_ST_READ;
          end
        end
        DSAIR_ST_READ: begin
          if (BUS_ACK) begin
            state_q <= DSAIR_ST_WRITE;
          end
        end
        DSAIR_ST_WRITE: begin
          if (BUS_ACK) begin
            state_q <= DSAIR_ST_WAIT;
          end
        end
      endcase
    end
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      data_q <= 16'h0000;
    end else if (state_q == DSAIR_ST_READ && BUS_ACK) begin
      data_q <= BUS_RDATA;
    end
  end

  // bus address: io side is all ones over the low byte
  logic [23:0] io_full;
  assign io_full = {DSAIR_IO_UPPER, io_addr_q};
  always_comb begin
    BUS_REQ   = (state_q != DSAIR_ST_WAIT);
    BUS_WRITE = (state_q == DSAIR_ST_WRITE);
    BUS_WORD  = size_q;
    BUS_WDATA = data_q;
    if (state_q == DSAIR_ST_READ) begin
      BUS_ADDR = rx_dir ? io_full : mem_addr_q;
    end else begin
      BUS_ADDR = rx_dir ? mem_addr_q : io_full;
    end
  end

  // the source is acknowledged once its unit has been written
  always_comb begin
    REQ_ACK = 7'h00;
    if (xfer_end && src_q != DSAIR_SRC_NONE) begin
      REQ_ACK[src_q] = 1'b1;
    end
  end

  //============================================================================
  // count and address update
  logic [7:0]  rpt_hi;
  logic [7:0]  rpt_lo;
  logic [23:0] step;
  logic [23:0] rewind;
  assign rpt_hi = count_q[15:8];
  assign rpt_lo = count_q[7:0];
  assign step   = size_q ? 24'h000002 : 24'h000001;
  // a word step is a shift, so the rewind needs no multiplier
  assign rewind = size_q ? {15'h0000, rpt_lo, 1'b0} : {16'h0000, rpt_lo};

  logic [23:0] addr_step;
  assign addr_step = dir_q ? (mem_addr_q - step) : (mem_addr_q + step);

  // idle count of zero wraps to ffff first: 65536 transfers
  assign done_ev = xfer_end && (mode_q == DSAIR_MODE_IDLE)
                   && (count_q == 16'h0001);

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      count_q <= DSAIR_RST_COUNT;
    end else if (sw_wr && PADDR == DSAIR_OFF_COUNT) begin
      count_q <= PWDATA[15:0];
    end else if (xfer_end) begin
      if (mode_q == DSAIR_MODE_IDLE) begin
        count_q <= count_q - 16'h0001;
      end else if (rpt_hi == 8'h01) begin
        count_q <= {rpt_lo, rpt_lo};
      end else begin
        count_q <= {rpt_hi - 8'h01, rpt_lo};
      end
    end
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      mem_addr_q <= DSAIR_RST_MEM_ADDR;
    end else if (sw_wr && PADDR == DSAIR_OFF_MEM_ADDR) begin
      mem_addr_q <= PWDATA[23:0];
    end else if (xfer_end && mode_q == DSAIR_MODE_REPEAT) begin
      if (rpt_hi == 8'h01) begin
        // net effect: step applied, then rewound by step times initial count
        mem_addr_q <= dir_q ? (addr_step + rewind)
                            : (addr_step - rewind);
      end else begin
        mem_addr_q <= addr_step;
      end
    end
    // idle mode leaves the address untouched
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      io_addr_q <= DSAIR_RST_IO_ADDR;
    end else if (sw_wr && PADDR == DSAIR_OFF_IO_ADDR) begin
      io_addr_q <= PWDATA[7:0];
    end
  end

  //============================================================================
  // control: mode is per channel, chosen by software
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      size_q <= 1'b0;
      dir_q  <= 1'b0;
      mode_q <= DSAIR_MODE_IDLE;
      src_q  <= DSAIR_SRC_NONE;
    end else if (sw_wr && PADDR == DSAIR_OFF_CTRL) begin
      size_q <= PWDATA[DSAIR_CTRL_SIZE];
      dir_q  <= PWDATA[DSAIR_CTRL_DIR];
      mode_q <= dsair_mode_t'(PWDATA[DSAIR_CTRL_MODE]);
      src_q  <= dsair_src_t'(PWDATA[DSAIR_CTRL_SRC_LO +: DSAIR_SRC_W]);
    end
  end

  // active bit: software may write it at any time; a unit in flight ends
  // before the engine checks it again, so repeat state is kept intact
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      active_q <= 1'b0;
    end else if (done_ev) begin
      active_q <= 1'b0;
    end else if (wr_en && PADDR == DSAIR_OFF_CTRL) begin
      active_q <= PWDATA[DSAIR_CTRL_ACTIVE];
    end
  end

  //============================================================================
  // interrupt: only the idle completion sets it, never repeat
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      irq_stat_q <= '0;
    end else begin
      irq_stat_q[DSAIR_IRQ_DONE] <= done_ev
        || (irq_stat_q[DSAIR_IRQ_DONE]
            && !(wr_en && PADDR == DSAIR_OFF_IRQ_STAT
                 && PWDATA[DSAIR_IRQ_DONE]));
    end
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      irq_mask_q <= '0;
    end else if (wr_en && PADDR == DSAIR_OFF_IRQ_MASK) begin
      irq_mask_q <= PWDATA[DSAIR_IRQ_W-1:0];
    end
  end

  assign IRQ = |(irq_stat_q & irq_mask_q);

  //============================================================================
  // read data, registered at the setup cycle
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      PRDATA <= 32'h00000000;
    end else if (rd_en && !PENABLE) begin
      unique case (PADDR)
        DSAIR_OFF_MEM_ADDR: PRDATA <= {8'h00, mem_addr_q};
        DSAIR_OFF_IO_ADDR:  PRDATA <= {24'h000000, io_addr_q};
        DSAIR_OFF_COUNT:    PRDATA <= {16'h0000, count_q};
        DSAIR_OFF_CTRL:     PRDATA <= {25'h0000000, src_q, mode_q,
                                       dir_q, size_q, active_q};
        DSAIR_OFF_STATUS:   PRDATA <= {30'h00000000, state_q};
        DSAIR_OFF_IRQ_STAT: PRDATA <= {31'h00000000, irq_stat_q};
        DSAIR_OFF_IRQ_MASK: PRDATA <= {31'h00000000, irq_mask_q};
        default:            PRDATA <= 32'h00000000;
      endcase
    end
  end

endmodule : dsair_channel

// >>> rtl/dsair_pkg.sv
// package: register map, field layout and constants of the short-address dma channel
//==============================================================================
// Contract
// - idle mode is chosen per channel, independent of other channels
// - idle mode moves one unit per accepted request until count done
// - receive-full request copies io to memory; others memory to io
// - memory address 24 bits; io address is all ones over 8-bit low part
// - idle mode keeps memory and io addresses fixed
// - idle mode decrements 16-bit count; at zero clears active, interrupts
// - idle count programmed zero gives 65536 transfers
// - accepted sources: timer 0-2, serial tx/rx, converter end, external
// - repeat mode is chosen per channel, independent of other channels
// - repeat uses high byte as down-counter, low byte reloads it
// - repeat steps memory address, rewinds by step times initial count
// - repeat runs until active cleared; resumes from held state
// - repeat mode never raises an interrupt
// - repeat counts of all ones give 255 transfers per cycle
package dsair_pkg;

  //============================================================================
  // register byte offsets
  localparam logic [7:0] DSAIR_OFF_MEM_ADDR = 8'h00;
  localparam logic [7:0] DSAIR_OFF_IO_ADDR  = 8'h04;
  localparam logic [7:0] DSAIR_OFF_COUNT    = 8'h08;
  localparam logic [7:0] DSAIR_OFF_CTRL     = 8'h0c;
  localparam logic [7:0] DSAIR_OFF_STATUS   = 8'h10;
  localparam logic [7:0] DSAIR_OFF_IRQ_STAT = 8'h14;
  localparam logic [7:0] DSAIR_OFF_IRQ_MASK = 8'h18;

  //============================================================================
  // control register fields
  localparam int DSAIR_CTRL_ACTIVE = 0;
  localparam int DSAIR_CTRL_SIZE   = 1;
  localparam int DSAIR_CTRL_DIR    = 2;
  localparam int DSAIR_CTRL_MODE   = 3;
  localparam int DSAIR_CTRL_SRC_LO = 4;
  localparam int DSAIR_SRC_W       = 3;

  // interrupt status fields
  localparam int DSAIR_IRQ_DONE = 0;
  localparam int DSAIR_IRQ_W    = 1;

  //============================================================================
  // reset values
  localparam logic [23:0] DSAIR_RST_MEM_ADDR = 24'h000000;
  localparam logic [7:0]  DSAIR_RST_IO_ADDR  = 8'h00;
  localparam logic [15:0] DSAIR_RST_COUNT    = 16'h0000;
  localparam logic [15:0] DSAIR_IO_UPPER     = 16'hffff;

  //============================================================================
  // enumerations
  typedef enum logic {
    DSAIR_MODE_IDLE,
    DSAIR_MODE_REPEAT
  } dsair_mode_t;

  typedef enum logic [2:0] {
    DSAIR_SRC_TMR0,
    DSAIR_SRC_TMR1,
    DSAIR_SRC_TMR2,
    DSAIR_SRC_SER_TX,
    DSAIR_SRC_SER_RX,
    DSAIR_SRC_ADC,
    DSAIR_SRC_EXT,
    DSAIR_SRC_NONE
  } dsair_src_t;

  typedef enum logic [1:0] {
    DSAIR_ST_WAIT,
    DSAIR_ST_READ,
    DSAIR_ST_WRITE
  } dsair_state_t;

endpackage : dsair_pkg

// >>> verification/dsair_bus_model.sv
// partner: system bus with address-derived read data, answering after a chosen wait
`timescale 1ns/1ps
module dsair_bus_model (
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        bus_req,
  input  wire logic        bus_write,
  input  wire logic [23:0] bus_addr,
  input  wire logic [15:0] bus_wdata,
  input  wire logic [3:0]  wait_cycles,
  output logic      [15:0] bus_rdata,
  output logic             bus_ack,
  output logic      [23:0] last_raddr,
  output logic      [23:0] last_waddr,
  output logic      [15:0] last_wdata
);
  logic [3:0] cnt_q;
  // read data is a function of the address; outside acks it toggles so a
  // design sampling at the wrong edge sees garbage
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      bus_ack   <= 1'b0;
      cnt_q     <= 4'h0;
      bus_rdata <= 16'h0000;
      last_raddr <= 24'h000000;
      last_waddr <= 24'h000000;
      last_wdata <= 16'h0000;
    end else if (bus_req && !bus_ack && cnt_q >= wait_cycles) begin
      bus_ack <= 1'b1;
      cnt_q   <= 4'h0;
      bus_rdata <= bus_addr[15:0] ^ 16'h5a5a;
      if (bus_write) begin
        last_waddr <= bus_addr;
        last_wdata <= bus_wdata;
      end else begin
        last_raddr <= bus_addr;
      end
    end else begin
      bus_ack   <= 1'b0;
      bus_rdata <= ~bus_rdata;
      if (bus_req && !bus_ack) cnt_q <= cnt_q + 4'h1;
    end
  end
endmodule : dsair_bus_model

// >>> verification/dsair_channel_sva.sv
// checker: bus cycle and apb assertions of the dma channel
`timescale 1ns/1ps
module dsair_channel_sva (
  // clock and reset
  input wire logic        CLK,
  input wire logic        RSTN,
  // apb
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic [7:0]  PADDR,
  input wire logic        PREADY,
  input wire logic        PSLVERR,
  // system bus and acknowledge
  input wire logic        BUS_REQ,
  input wire logic        BUS_WRITE,
  input wire logic [23:0] BUS_ADDR,
  input wire logic [15:0] BUS_WDATA,
  input wire logic [15:0] BUS_RDATA,
  input wire logic        BUS_ACK,
  input wire logic [6:0]  REQ_ACK
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RSTN);
  //============================================================================
  // bus cycle steps
  sequence s_rd_done;
    BUS_REQ && !BUS_WRITE && BUS_ACK;
  endsequence
  sequence s_wr_done;
    BUS_REQ && BUS_WRITE && BUS_ACK;
  endsequence
  //============================================================================
  // transfer
  a_ack_on_write: assert property (|REQ_ACK |-> s_wr_done)
    else $error("source acknowledge outside a write completion");
  a_one_unit: assert property (|REQ_ACK |=> !BUS_REQ)
    else $error("bus still requested after the unit was moved");
  a_ack_onehot: assert property ($onehot0(REQ_ACK))
    else $error("more than one source acknowledged");
  a_write_follows: assert property (
    s_rd_done |=> BUS_REQ && BUS_WRITE)
    else $error("read completion not followed by a write cycle");
  a_data_moved: assert property (
    s_rd_done |=> BUS_WDATA[7:0] == $past(BUS_RDATA[7:0]))
    else $error("written data differs from data read");
  a_io_dest: assert property (
    (|REQ_ACK[3:0] || |REQ_ACK[6:5]) |-> BUS_ADDR[23:8] == 16'hffff)
    else $error("io destination upper address not all ones");
  a_bus_hold: assert property (BUS_REQ && !BUS_ACK |=>
    BUS_REQ && $stable(BUS_ADDR) && $stable(BUS_WRITE))
    else $error("bus cycle changed before completion");
  //============================================================================
  // apb
  a_apb_ready: assert property (PSEL && PENABLE |-> PREADY)
    else $error("apb access not completed at once");
  a_unmapped_err: assert property (
    PSEL && PENABLE && PADDR > 8'h18 |-> PSLVERR)
    else $error("unmapped access not flagged");
endmodule : dsair_channel_sva

bind dsair_channel dsair_channel_sva dsair_channel_sva_inst (
  .CLK(CLK), .RSTN(RSTN), .PSEL(PSEL), .PENABLE(PENABLE), .PADDR(PADDR),
  .PREADY(PREADY), .PSLVERR(PSLVERR), .BUS_REQ(BUS_REQ),
  .BUS_WRITE(BUS_WRITE), .BUS_ADDR(BUS_ADDR), .BUS_WDATA(BUS_WDATA),
  .BUS_RDATA(BUS_RDATA), .BUS_ACK(BUS_ACK), .REQ_ACK(REQ_ACK));

// >>> verification/testbench.sv
// testbench: apb-driven scenarios of the short-address dma channel
`timescale 1ns/1ps
module testbench;
  import dsair_pkg::*;
  logic        clk, rstn, psel, penable, pwrite, ext_pin, pready, pslverr;
  logic        perr;
  logic        bus_req, bus_write, bus_word, bus_ack, irq;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [23:0] bus_addr, last_raddr, last_waddr, memx, iox;
  logic [15:0] bus_wdata, bus_rdata, last_wdata;
  logic [6:0]  req, req_ack;
  logic [3:0]  slow;
  int          err_count, n_checks, s;

  dsair_channel dsair_channel_inst (.CLK(clk), .RSTN(rstn), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .REQ(req),
    .EXT_REQ_PIN(ext_pin), .BUS_REQ(bus_req), .BUS_WRITE(bus_write),
    .BUS_WORD(bus_word), .BUS_ADDR(bus_addr), .BUS_WDATA(bus_wdata),
    .BUS_RDATA(bus_rdata), .BUS_ACK(bus_ack), .REQ_ACK(req_ack), .IRQ(irq));
  dsair_bus_model dsair_bus_model_inst (.clk(clk), .rstn(rstn),
    .bus_req(bus_req), .bus_write(bus_write), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .wait_cycles(slow), .bus_rdata(bus_rdata),
    .bus_ack(bus_ack), .last_raddr(last_raddr), .last_waddr(last_waddr),
    .last_wdata(last_wdata));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  //============================================================================
  // tasks
  task automatic final_report();
    if (err_count == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : final_report
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    for (i = 0; i < 16; i++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    if (i == 16) begin
      err_count++;
      final_report();
    end
    rd   = prdata;
    perr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    // let one edge pass so the next call never reassigns psel in this step
    @(posedge clk);
  endtask : apb
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask : rdchk
  // irq is combinational from registers: look at it mid-cycle
  task automatic irqchk(input logic exp);
    @(negedge clk);
    chk({31'h0, irq}, {31'h0, exp});
    @(posedge clk);
  endtask : irqchk
  // source holds its level until acknowledged, then drops it at that edge;
  // source 7 stands for the external pin, which feeds source 6
  task automatic xfer(input int src);
    int i;
    int b;
    b = (src == 7) ? 6 : src;
    if (src == 7) ext_pin <= 1'b1;
    else req[b] <= 1'b1;
    for (i = 0; i < 200; i++) begin
      @(negedge clk);
      if (req_ack[b] === 1'b1) break;
    end
    if (i == 200) begin
      err_count++;
      final_report();
    end
    @(posedge clk);
    if (src == 7) ext_pin <= 1'b0;
    else req[b] <= 1'b0;
    // one edge with the source low before any further request
    @(posedge clk);
  endtask : xfer
  //============================================================================
  // scenarios
  initial begin
    rstn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 8'h00; pwdata = 32'h0; req = 7'h00; ext_pin = 1'b0; slow = 4'h0;
    err_count = 0;
    n_checks = 0;
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    rdchk(DSAIR_OFF_CTRL, 32'h70);
    rdchk(DSAIR_OFF_COUNT, 32'h0);
    chk({31'h0, perr}, 32'h0);
    rdchk(8'h1c, 32'h0);
    chk({31'h0, perr}, 32'h1);
    apb(1'b1, DSAIR_OFF_IRQ_MASK, 32'h1);
    // every source, idle byte mode, single transfer
    for (s = 0; s < 7; s++) begin
      memx = 24'h001234 + 24'(s);
      iox  = {16'hffff, 8'h50 + 8'(s)};
      apb(1'b1, DSAIR_OFF_MEM_ADDR, {8'h0, memx});
      apb(1'b1, DSAIR_OFF_IO_ADDR, {24'h0, iox[7:0]});
      apb(1'b1, DSAIR_OFF_COUNT, 32'h1);
      apb(1'b1, DSAIR_OFF_CTRL, 32'(s << 4) | 32'h1);
      xfer(s);
      chk({8'h0, last_raddr}, {8'h0, (s == 4) ? iox : memx});
      chk({8'h0, last_waddr}, {8'h0, (s == 4) ? memx : iox});
      chk({24'h0, last_wdata[7:0]}, {24'h0, ((s == 4) ? iox[7:0] : memx[7:0])
          ^ 8'h5a});
      rdchk(DSAIR_OFF_CTRL, 32'(s << 4));
      rdchk(DSAIR_OFF_IRQ_STAT, 32'h1);
      irqchk(1'b1);
      apb(1'b1, DSAIR_OFF_IRQ_MASK, 32'h0);
      irqchk(1'b0);
      apb(1'b1, DSAIR_OFF_IRQ_MASK, 32'h1);
      apb(1'b1, DSAIR_OFF_IRQ_STAT, 32'h1);
      irqchk(1'b0);
    end
    // external pin through the synchroniser as source 6
    apb(1'b1, DSAIR_OFF_COUNT, 32'h1);
    apb(1'b1, DSAIR_OFF_CTRL, 32'h61);
    xfer(7);
    chk({8'h0, last_waddr}, 32'hffff56);
    rdchk(DSAIR_OFF_CTRL, 32'h60);
    rdchk(DSAIR_OFF_IRQ_STAT, 32'h1);
    apb(1'b1, DSAIR_OFF_IRQ_STAT, 32'h1);
    // count of zero is the longest run; addresses stay put
    apb(1'b1, DSAIR_OFF_COUNT, 32'h0);
    apb(1'b1, DSAIR_OFF_CTRL, 32'h01);
    xfer(0);
    xfer(0);
    chk({8'h0, last_raddr}, 32'h00123a);
    rdchk(DSAIR_OFF_MEM_ADDR, 32'h00123a);
    rdchk(DSAIR_OFF_COUNT, 32'hfffe);
    rdchk(DSAIR_OFF_CTRL, 32'h01);
    // inactive channel ignores its request
    apb(1'b1, DSAIR_OFF_CTRL, 32'h00);
    req[0] <= 1'b1;
    repeat (10) @(posedge clk);
    req[0] <= 1'b0;
    rdchk(DSAIR_OFF_COUNT, 32'hfffe);
    // repeat mode, word, increment, slow bus
    slow <= 4'h3;
    apb(1'b1, DSAIR_OFF_MEM_ADDR, 32'h000100);
    apb(1'b1, DSAIR_OFF_COUNT, 32'h0202);
    apb(1'b1, DSAIR_OFF_CTRL, 32'h0b);
    chk({31'h0, bus_word}, 32'h1);
    xfer(0);
    rdchk(DSAIR_OFF_COUNT, 32'h0102);
    xfer(0);
    chk({8'h0, last_raddr}, 32'h000102);
    rdchk(DSAIR_OFF_MEM_ADDR, 32'h000100);
    rdchk(DSAIR_OFF_COUNT, 32'h0202);
    xfer(0);
    apb(1'b1, DSAIR_OFF_CTRL, 32'h0a);
    rdchk(DSAIR_OFF_MEM_ADDR, 32'h000102);
    rdchk(DSAIR_OFF_COUNT, 32'h0102);
    apb(1'b1, DSAIR_OFF_CTRL, 32'h0b);
    xfer(0);
    chk({8'h0, last_raddr}, 32'h000102);
    rdchk(DSAIR_OFF_IRQ_STAT, 32'h0);
    irqchk(1'b0);
    apb(1'b1, DSAIR_OFF_COUNT, 32'hffff);
    xfer(0);
    rdchk(DSAIR_OFF_COUNT, 32'hfeff);
    final_report();
  end
endmodule : testbench
